/* File: smbws_pkg.sv */
// Package for the static memory strobe sequencer: timing constants,
// state names and the carrier for the wait-state settings.
// Assumes one system clock split into quadrature ticks by the clocking logic.
package smbws_pkg;

  // One system period is four quadrature ticks; the sequencer runs per tick
  localparam int unsigned TICKS_PER_PERIOD = 4;
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;

  // Width of each wait-state count
  localparam int unsigned WAIT_W = 4;
  // Tick counter width: 4 * max count plus fixed part
  localparam int unsigned TICK_W = WAIT_W + 3;

  // Fixed parts, in ticks (quarter periods)
  localparam logic [TICK_W-1:0] RD_SETUP_FIX = 7'h0;
  localparam logic [TICK_W-1:0] RD_STROBE_FIX = 7'h4;
  localparam logic [TICK_W-1:0] RD_HOLD_FIX = 7'h0;
  localparam logic [TICK_W-1:0] WR_SETUP_FIX_ZERO = 7'h2;
  localparam logic [TICK_W-1:0] WR_SETUP_FIX_WAIT = 7'h3;
  localparam logic [TICK_W-1:0] WR_STROBE_FIX_ZERO = 7'h1;
  localparam logic [TICK_W-1:0] WR_HOLD_FIX = 7'h1;
  localparam logic [TICK_W-1:0] DATA_HOLD_FIX = 7'h0;
  localparam logic [TICK_W-1:0] INTERNAL_TICKS = 7'h1;

  // Reset values of the bus pins
  localparam logic STROBE_IDLE_N = 1'b1;

  typedef enum logic [2:0] {
    SMBWS_IDLE,
    SMBWS_DEAD,
    SMBWS_SETUP,
    SMBWS_STROBE,
    SMBWS_HOLD,
    SMBWS_INTERNAL
  } smbws_state_t;

  typedef struct packed {
    logic [WAIT_W-1:0] read_setup_wait_count;
    logic [WAIT_W-1:0] read_strobe_wait_count;
    logic [WAIT_W-1:0] read_hold_wait_count;
    logic [WAIT_W-1:0] write_setup_wait_count;
    logic [WAIT_W-1:0] write_strobe_wait_count;
    logic [WAIT_W-1:0] write_hold_wait_count;
    logic [WAIT_W-1:0] cs_change_dead_cycles;
    logic [WAIT_W-1:0] no_cs_dead_cycles;
  } smbws_wait_cfg_t;

endpackage : smbws_pkg

/* File: smbws_seq.sv */
// Strobe sequencer of the external memory port: address, chip select,
// read and write strobes and write data, stretched by wait-state counts.
// Assumes clk is the quadrature tick clock (four ticks per system period)
// and that all inputs are synchronous to it.
//
// What this block does
// - every interval grows one period per applicable wait unit, plus fixed ticks.
// - read strobe asserts dead plus read-setup periods after address valid.
// - address valid to read strobe release is one plus dead, setup and strobe periods.
// - read strobe stays asserted one period plus read strobe count.
// - address held read-hold periods after read strobe release.
// - read data sampled in the last tick before read strobe release.
// - zero read setup and hold, same chip select: read strobe stays on.
// - read-to-read gap is hold plus setup plus dead cycles when applicable.
// - dead cycles follow a read only when the chip select changes.
// - region without chip select uses the no-chip-select dead count.
// - write sequencing differs for zero and nonzero write strobe count.
// - write strobe after address by dead, setup plus half or three quarter period.
// - write strobe lasts a quarter period, or write-strobe-count whole periods.
// - address kept quarter period plus hold; data kept write-hold periods.
// - write-to-write gap is hold plus setup plus three quarter or one period.
// - write-to-read gap is quarter period plus write hold plus read setup.
// - read-to-write gap is hold, setup, dead, plus half or three quarters.
// - internal cycles leave the address lines unchanged.
// - with prescaler clock at divide by one, quadrature comes from both edges.
`timescale 1ns/1ps
module smbws_seq
  import smbws_pkg::*;
#(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned DATA_W = 16,
  parameter int unsigned NUM_CS = 4
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Configuration
  input wire smbws_pkg::smbws_wait_cfg_t wait_cfg,
  input wire logic core_clock_source_select,
  input wire logic prescaler_div1,
  // Request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_internal,
  input wire logic req_no_cs,
  input wire logic [$clog2(NUM_CS)-1:0] req_cs_sel,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ack,
  // Read answer
  output logic [DATA_W-1:0] rd_data,
  output logic rd_data_valid,
  // Memory pins
  output logic [ADDR_W-1:0] mem_addr,
  output logic [NUM_CS-1:0] mem_cs_n,
  output logic mem_rd_n,
  output logic mem_wr_n,
  input wire logic [DATA_W-1:0] mem_data_in,
  output logic [DATA_W-1:0] mem_data_out,
  output logic mem_data_oe,
  // Status
  output logic quad_from_ext_edges,
  output logic busy
);
  import smbws_pkg::*;

  localparam int unsigned CS_W = $clog2(NUM_CS);

  if (NUM_CS < 2 || ADDR_W < 1 || DATA_W < 1) begin : g_bad_param
    $error("smbws_seq: NUM_CS must be at least 2, widths at least 1");
  end

  logic rst_sync1_reg;
  logic rst_sync2_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  wire logic rst_int_n = rst_sync2_reg;

  smbws_state_t state_reg, state_next;
  logic [TICK_W-1:0] cnt_reg, cnt_next;
  logic cur_write_reg, cur_no_cs_reg, prev_read_reg;
  logic [CS_W-1:0] cur_cs_reg;
  logic [DATA_W-1:0] cur_wdata_reg;
  logic take;

  // Phase length in ticks: four per wait unit plus fixed quarters
  function automatic logic [TICK_W-1:0] wunits(input logic [WAIT_W-1:0] n);
    wunits = {1'b0, n, 2'b00};
  endfunction : wunits

  function automatic logic [TICK_W-1:0] setup_len(input logic wr, input smbws_wait_cfg_t c);
    if (!wr)
      setup_len = wunits(c.read_setup_wait_count) + RD_SETUP_FIX;
    else if (c.write_strobe_wait_count == '0)
      setup_len = wunits(c.write_setup_wait_count) + WR_SETUP_FIX_ZERO;
    else
      setup_len = wunits(c.write_setup_wait_count) + WR_SETUP_FIX_WAIT;
  endfunction : setup_len

  function automatic logic [TICK_W-1:0] strobe_len(input logic wr, input smbws_wait_cfg_t c);
    if (!wr)
      strobe_len = wunits(c.read_strobe_wait_count) + RD_STROBE_FIX;
    else if (c.write_strobe_wait_count == '0)
      strobe_len = WR_STROBE_FIX_ZERO;
    else
      strobe_len = wunits(c.write_strobe_wait_count);
  endfunction : strobe_len

  function automatic logic [TICK_W-1:0] hold_len(input logic wr, input smbws_wait_cfg_t c);
    if (!wr)
      hold_len = wunits(c.read_hold_wait_count) + RD_HOLD_FIX;
    else
      hold_len = wunits(c.write_hold_wait_count) + WR_HOLD_FIX;
  endfunction : hold_len

  // Dead ticks only after a read whose chip select differs from the next
  logic cs_changes;
  logic [TICK_W-1:0] dead_len;
  always_comb begin
    cs_changes = req_no_cs || cur_no_cs_reg || (req_cs_sel != cur_cs_reg);
    if (!prev_read_reg || !cs_changes)
      dead_len = '0;
    else if (req_no_cs)
      dead_len = wunits(wait_cfg.no_cs_dead_cycles);
    else
      dead_len = wunits(wait_cfg.cs_change_dead_cycles);
  end

  // Phase lengths for the request in flight
  logic [TICK_W-1:0] cur_setup, cur_strobe, cur_hold, new_setup;
  always_comb begin
    cur_setup = setup_len(cur_write_reg, wait_cfg);
    cur_strobe = strobe_len(cur_write_reg, wait_cfg);
    cur_hold = hold_len(cur_write_reg, wait_cfg);
    new_setup = setup_len(req_write, wait_cfg);
  end

  // Back-to-back gaps come out as hold, then dead, then the next setup
  logic done, finish;
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg - 7'h1;
    done = (cnt_reg == '0);
    finish = 1'b0;
    unique case (state_reg)
      SMBWS_IDLE: finish = 1'b1;
      SMBWS_INTERNAL: finish = done;
      SMBWS_DEAD: begin
        if (done) begin
          if (cur_setup != '0) begin
            state_next = SMBWS_SETUP;
            cnt_next = cur_setup - 7'h1;
          end else begin
            state_next = SMBWS_STROBE;
            cnt_next = cur_strobe - 7'h1;
          end
        end
      end
      SMBWS_SETUP: begin
        if (done) begin
          state_next = SMBWS_STROBE;
          cnt_next = cur_strobe - 7'h1;
        end
      end
      SMBWS_STROBE: begin
        if (done) begin
          if (cur_hold != '0) begin
            state_next = SMBWS_HOLD;
            cnt_next = cur_hold - 7'h1;
          end else begin
            finish = 1'b1;
          end
        end
      end
      SMBWS_HOLD: finish = done;
    endcase
    if (finish) begin
      state_next = SMBWS_IDLE;
      cnt_next = '0;
    end
    take = finish && req_valid && !req_ack;
    if (take) begin
      if (req_internal) begin
        state_next = SMBWS_INTERNAL;
        cnt_next = INTERNAL_TICKS - 7'h1;
      end else if (dead_len != '0) begin
        state_next = SMBWS_DEAD;
        cnt_next = dead_len - 7'h1;
      end else if (new_setup != '0) begin
        state_next = SMBWS_SETUP;
        cnt_next = new_setup - 7'h1;
      end else begin
        // Zero setup after zero hold on the same select keeps read strobe on
        state_next = SMBWS_STROBE;
        cnt_next = strobe_len(req_write, wait_cfg) - 7'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_reg <= SMBWS_IDLE;
      cnt_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Latched request; internal cycles keep the previous access context
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cur_write_reg <= 1'b0;
      cur_no_cs_reg <= 1'b1;
      cur_cs_reg <= '0;
      cur_wdata_reg <= '0;
      prev_read_reg <= 1'b0;
    end else if (ce && take && !req_internal) begin
      cur_write_reg <= req_write;
      cur_no_cs_reg <= req_no_cs;
      cur_cs_reg <= req_cs_sel;
      cur_wdata_reg <= req_wdata;
      prev_read_reg <= !req_write;
    end
  end

  // Acknowledge; the requester drops valid in the ack cycle
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n)
      req_ack <= 1'b0;
    else if (ce)
      req_ack <= take;
  end

  // Address changes only when a real access is taken
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n)
      mem_addr <= '0;
    else if (ce && take && !req_internal)
      mem_addr <= req_addr;
  end

  // Pins are registered from the next state so they align with the phase
  logic next_access;
  logic next_wr;
  logic [CS_W-1:0] next_cs;
  logic next_no_cs;
  always_comb begin
    next_access = (state_next == SMBWS_SETUP) || (state_next == SMBWS_STROBE)
                  || (state_next == SMBWS_HOLD);
    next_wr = (take && !req_internal) ? req_write : cur_write_reg;
    next_cs = (take && !req_internal) ? req_cs_sel : cur_cs_reg;
    next_no_cs = (take && !req_internal) ? req_no_cs : cur_no_cs_reg;
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      mem_rd_n <= STROBE_IDLE_N;
      mem_wr_n <= STROBE_IDLE_N;
    end else if (ce) begin
      mem_rd_n <= !(state_next == SMBWS_STROBE && !next_wr);
      mem_wr_n <= !(state_next == SMBWS_STROBE && next_wr);
    end
  end

  // One select line per region; asserted across setup, strobe and hold
  for (genvar i = 0; i < NUM_CS; i++) begin : g_cs
    always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n)
        mem_cs_n[i] <= STROBE_IDLE_N;
      else if (ce)
        mem_cs_n[i] <= !(next_access && !next_no_cs
                         && next_cs == CS_W'(i));
    end
  end

  // Write data ends one quarter before the address does
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      mem_data_out <= '0;
      mem_data_oe <= 1'b0;
    end else if (ce) begin
      mem_data_out <= (take && !req_internal) ? req_wdata : cur_wdata_reg;
      mem_data_oe <= next_wr && next_access
                     && !(state_next == SMBWS_HOLD && cnt_next == DATA_HOLD_FIX);
    end
  end

  // Capture in the final strobe tick so the memory need not hold data
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rd_data <= '0;
      rd_data_valid <= 1'b0;
    end else if (ce) begin
      rd_data_valid <= 1'b0;
      if (state_reg == SMBWS_STROBE && done && !cur_write_reg) begin
        rd_data <= mem_data_in;
        rd_data_valid <= 1'b1;
      end
    end
  end

  // Quadrature source flag for the clock generator outside
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      quad_from_ext_edges <= 1'b0;
      busy <= 1'b0;
    end else if (ce) begin
      quad_from_ext_edges <= core_clock_source_select && prescaler_div1;
      busy <= (state_next != SMBWS_IDLE);
    end
  end

endmodule : smbws_seq

/* File: smbws_props.sv */
// Checker for the strobe sequencer pins, bound to the smbws_seq module.
// Assumes clk is the tick clock and wait settings change only when idle.
`timescale 1ns/1ps
module smbws_props
  import smbws_pkg::*;
#(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned DATA_W = 16,
  parameter int unsigned NUM_CS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs watched
  input wire smbws_pkg::smbws_wait_cfg_t wait_cfg,
  input wire logic req_write,
  input wire logic req_internal,
  input wire logic core_clock_source_select,
  input wire logic prescaler_div1,
  input wire logic [DATA_W-1:0] mem_data_in,
  // Outputs watched
  input wire logic req_ack,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_data_valid,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [NUM_CS-1:0] mem_cs_n,
  input wire logic mem_rd_n,
  input wire logic mem_wr_n,
  input wire logic mem_data_oe,
  input wire logic quad_from_ext_edges
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] rd_len;
  logic no_dead;
  // Dead cycles shift setup away from the ack, so setup checks skip them
  assign no_dead = wait_cfg.cs_change_dead_cycles == 4'h0 && wait_cfg.no_cs_dead_cycles == 4'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_len <= 8'h0;
    else rd_len <= mem_rd_n ? 8'h0 : rd_len + 8'h1;
  end
  a_rd_strobe_len: assert property ($rose(mem_rd_n) |-> rd_len[1:0] == 2'h0 && rd_len != 8'h0)
    else $error("read strobe not whole periods");
  a_rd_addr_stable: assert property (!mem_rd_n && !$past(mem_rd_n) && !rd_data_valid
    |-> $stable(mem_addr) && $stable(mem_cs_n)) else $error("address moved in read strobe");
  a_rd_sample: assert property (rd_data_valid |-> !$past(mem_rd_n) && rd_data == $past(mem_data_in))
    else $error("read data not taken inside strobe");
  a_rd_setup_zero: assert property (req_ack && !$past(req_write) && !$past(req_internal) && no_dead
    && wait_cfg.read_setup_wait_count == 4'h0 |-> !mem_rd_n) else $error("read strobe late");
  a_rd_setup_one: assert property (req_ack && !$past(req_write) && !$past(req_internal) && no_dead
    && wait_cfg.read_setup_wait_count == 4'h1 |-> mem_rd_n [*4] ##1 !mem_rd_n)
    else $error("read setup not one period");
  a_wr_setup_zero: assert property (req_ack && $past(req_write) && !$past(req_internal) && no_dead
    && wait_cfg.write_setup_wait_count == 4'h0 && wait_cfg.write_strobe_wait_count == 4'h0
    |-> mem_wr_n [*2] ##1 !mem_wr_n) else $error("write setup not half period");
  a_wr_strobe_short: assert property ($fell(mem_wr_n) && wait_cfg.write_strobe_wait_count == 4'h0
    |=> mem_wr_n) else $error("short write strobe too long");
  a_wr_strobe_long: assert property ($fell(mem_wr_n) && wait_cfg.write_strobe_wait_count == 4'h1
    |-> !mem_wr_n [*4] ##1 mem_wr_n) else $error("write strobe not one period");
  a_wr_data_hold: assert property ($rose(mem_wr_n) && wait_cfg.write_hold_wait_count == 4'h1
    |-> mem_data_oe [*4]) else $error("write data dropped early");
  a_quad_flag: assert property (core_clock_source_select && prescaler_div1 |=> quad_from_ext_edges)
    else $error("quadrature source flag missing");
  a_internal_addr: assert property (req_ack && $past(req_internal) |-> $stable(mem_addr))
    else $error("internal cycle moved address");
  c_merged_read: cover property (rd_data_valid && !mem_rd_n);
  c_write_strobe: cover property ($fell(mem_wr_n));
  c_internal: cover property (req_ack && $past(req_internal));
endmodule : smbws_props
bind smbws_seq smbws_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .NUM_CS(NUM_CS)) u_props (
  .clk(clk), .rst_n(rst_n), .wait_cfg(wait_cfg), .req_write(req_write),
  .req_internal(req_internal), .core_clock_source_select(core_clock_source_select),
  .prescaler_div1(prescaler_div1), .mem_data_in(mem_data_in), .req_ack(req_ack),
  .rd_data(rd_data), .rd_data_valid(rd_data_valid), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
  .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n), .mem_data_oe(mem_data_oe),
  .quad_from_ext_edges(quad_from_ext_edges));

/* File: smbws_mem_model.sv */
// Static memory model on the far side of the strobe pins.
// Assumes 16 words decoded from the low address bits; regions share it.
`timescale 1ns/1ps
module smbws_mem_model #(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned DATA_W = 16
) (
  // Clock
  input wire logic clk,
  // Memory pins
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_rd_n,
  input wire logic mem_wr_n,
  input wire logic [DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe,
  output logic [DATA_W-1:0] mem_data_in
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] last;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = DATA_W'(32'h1000 + i);
    last = '0;
  end
  always @(posedge clk) begin
    if (!mem_wr_n && mem_data_oe) mem[mem_addr[3:0]] <= mem_data_out;
    if (!mem_rd_n) last <= mem[mem_addr[3:0]];
  end
  // No data hold after the strobe, so a late sample sees garbage
  assign mem_data_in = !mem_rd_n ? mem[mem_addr[3:0]] : ~last;
endmodule : smbws_mem_model

/* File: smbws_tb_top.sv */
// Bench for the strobe sequencer: requests, pin timing and read data.
// Assumes the memory model on the pins and ce held high throughout.
`timescale 1ns/1ps
module smbws_tb_top;
  import smbws_pkg::*;
  logic clk, rst_n, ce, sel, div1, req_valid, req_write, req_internal, req_no_cs, req_ack;
  logic rd_data_valid, mem_rd_n, mem_wr_n, mem_data_oe, quad, busy;
  logic [1:0] req_cs_sel;
  logic [3:0] mem_cs_n;
  logic [15:0] req_addr, req_wdata, rd_data, mem_addr, mem_data_in, mem_data_out;
  smbws_wait_cfg_t cfg;
  int error_cnt, num_checks, falls, f0, slen, gap_run, last_len, last_gap;
  smbws_seq dut (.clk(clk), .rst_n(rst_n), .ce(ce), .wait_cfg(cfg),
    .core_clock_source_select(sel), .prescaler_div1(div1), .req_valid(req_valid),
    .req_write(req_write), .req_internal(req_internal), .req_no_cs(req_no_cs),
    .req_cs_sel(req_cs_sel), .req_addr(req_addr), .req_wdata(req_wdata), .req_ack(req_ack),
    .rd_data(rd_data), .rd_data_valid(rd_data_valid), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
    .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n), .mem_data_in(mem_data_in),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .quad_from_ext_edges(quad),
    .busy(busy));
  smbws_mem_model u_mem (.clk(clk), .mem_addr(mem_addr), .mem_rd_n(mem_rd_n),
    .mem_wr_n(mem_wr_n), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
    .mem_data_in(mem_data_in));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Strobe length and strobe-to-strobe gap, in ticks
  always @(posedge clk) begin
    if (!mem_rd_n || !mem_wr_n) begin
      if (slen == 0) begin
        falls <= falls + 1;
        last_gap <= gap_run;
      end
      slen <= slen + 1;
      gap_run <= 0;
    end else begin
      if (slen != 0) last_len <= slen;
      slen <= 0;
      gap_run <= gap_run + 1;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic req(input logic w, input logic in, input logic nc, input logic [1:0] cs,
      input logic [15:0] a, input logic [15:0] d);
    tick();
    {req_write, req_internal, req_no_cs, req_cs_sel, req_addr, req_wdata} = {w, in, nc, cs, a, d};
    req_valid = 1'b1;
    for (int i = 0; i < 200 && req_ack !== 1'b1; i++) tick();
    req_valid = 1'b0;
    chk(req_ack, 1'b1);
  endtask : req
  task automatic wait_rd(input logic [15:0] e);
    for (int i = 0; i < 200 && rd_data_valid !== 1'b1; i++) tick();
    chk(rd_data_valid, 1'b1);
    chk(rd_data, e);
    tick();
  endtask : wait_rd
  task automatic setcfg(input logic [31:0] c);
    for (int i = 0; i < 200 && busy !== 1'b0; i++) tick();
    chk(busy, 1'b0);
    tick();
    cfg = c;
  endtask : setcfg
  initial begin
    #500000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {rst_n, ce, sel, div1, req_valid, req_write, req_internal, req_no_cs} = 8'h40;
    {req_cs_sel, req_addr, req_wdata, cfg} = '0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) tick();
    chk({mem_rd_n, mem_wr_n, mem_cs_n, mem_data_oe, busy}, 8'hfc);
    // Nibbles: rd setup, strobe, hold, wr setup, strobe, hold, cs dead, no-cs dead
    setcfg(32'h02000000);
    req(0, 0, 0, 2'd0, 16'h0003, 16'h0);
    wait_rd(16'h1003);
    chk(last_len, 12);
    setcfg(32'h0);
    f0 = falls;
    req(0, 0, 0, 2'd0, 16'h0004, 16'h0);
    req(0, 0, 0, 2'd0, 16'h0005, 16'h0);
    wait_rd(16'h1004);
    wait_rd(16'h1005);
    chk(falls - f0, 1);
    chk(last_len, 8);
    setcfg(32'h00000012);
    req(0, 0, 0, 2'd0, 16'h0006, 16'h0);
    req(0, 0, 0, 2'd1, 16'h0007, 16'h0);
    wait_rd(16'h1006);
    wait_rd(16'h1007);
    chk(last_gap, 4);
    f0 = falls;
    req(0, 0, 0, 2'd1, 16'h0008, 16'h0);
    req(0, 0, 0, 2'd1, 16'h0009, 16'h0);
    wait_rd(16'h1008);
    wait_rd(16'h1009);
    chk(falls - f0, 1);
    // Back-to-back so the gap holds only the dead ticks, no idle time
    req(0, 0, 0, 2'd1, 16'h000f, 16'h0);
    req(0, 0, 1, 2'd0, 16'h000b, 16'h0);
    wait_rd(16'h100f);
    wait_rd(16'h100b);
    chk(last_gap, 8);
    setcfg(32'h10100000);
    // Data of the first read stands before the hold ends, so take it first
    req(0, 0, 0, 2'd0, 16'h000c, 16'h0);
    wait_rd(16'h100c);
    req(0, 0, 0, 2'd0, 16'h000d, 16'h0);
    wait_rd(16'h100d);
    chk(last_gap, 8);
    setcfg(32'h0);
    req(1, 0, 0, 2'd0, 16'h0002, 16'hbeef);
    req(1, 0, 0, 2'd0, 16'h0003, 16'hcafe);
    setcfg(32'h0);
    chk(last_len, 1);
    chk(last_gap, 3);
    req(1, 0, 0, 2'd0, 16'h0001, 16'h5a5a);
    req(0, 0, 0, 2'd0, 16'h0001, 16'h0);
    wait_rd(16'h5a5a);
    chk(last_gap, 1);
    setcfg(32'h00011100);
    req(1, 0, 0, 2'd0, 16'h0002, 16'h1234);
    req(1, 0, 0, 2'd0, 16'h0003, 16'h4321);
    setcfg(32'h00000010);
    chk(last_len, 4);
    chk(last_gap, 12);
    req(0, 0, 0, 2'd0, 16'h0002, 16'h0);
    req(1, 0, 0, 2'd1, 16'h000e, 16'h7777);
    wait_rd(16'h1234);
    setcfg(32'h0);
    chk(last_gap, 6);
    req(0, 0, 0, 2'd0, 16'h000a, 16'h0);
    req(0, 1, 0, 2'd0, 16'h0055, 16'h0);
    chk(mem_addr, 16'h000a);
    wait_rd(16'h100a);
    {sel, div1} = 2'b11;
    repeat (2) tick();
    chk(quad, 1'b1);
    div1 = 1'b0;
    repeat (2) tick();
    chk(quad, 1'b0);
    report_and_stop();
  end
endmodule : smbws_tb_top
